// [lcr_top.sv]
// LED current regulator: register slave, conversion sequencing, duty update
// ============================================================
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "lcr_map.svh"
module lcr_top (
    input wire logic clk,
    input wire logic resetn,
    input wire lcr_pkg::lcr_avs_req_t avs_req,
    output lcr_pkg::lcr_avs_rsp_t avs_rsp,
    output logic adc_start,
    output logic [3:0] adc_channel,
    input wire logic adc_done,
    input wire logic [15:0] adc_data,
    output logic [3:0] pwm_out,
    output logic [3:0] upper_saturation_flag,
    output logic [3:0] lower_saturation_flag
);
    import lcr_pkg::*;

    // ============================================================
    // State and helpers
    localparam lcr_top_t RST_S = '{
        fsm: LCR_IDLE,
        kp: `LCR_RST_KP,
        ki: `LCR_RST_KI,
        upper: `LCR_RST_UPPER,
        duty: {4{`LCR_RELOAD}},
        chan: `LCR_FIRST_CH,
        default: '0
    };

    lcr_top_t s;
    lcr_top_t next_s;
    logic proc_en;
    logic done_rise;
    logic pi_go;
    logic pi_done;
    logic [15:0] pi_out;
    logic [2:0] idx;
    logic [3:0] next_chan;
    logic upd;
    logic ovf;
    logic [31:0] rd_mux;
    logic req_any;

    function automatic logic [2:0] lcr_idx(input logic [3:0] c);
        return 3'(c - `LCR_FIRST_CH);
    endfunction : lcr_idx

    function automatic logic [3:0] lcr_next(input logic [3:0] c);
        return (c == `LCR_LAST_CH) ? `LCR_FIRST_CH : c + 4'h1;
    endfunction : lcr_next

    // ============================================================
    // Rate and sense-side decoding
    // The divider stays so a slower rate is one constant away
    assign proc_en = s.div == `LCR_PROC_DIV - 4'h1;
    assign done_rise = s.done_sync[1] & !s.done_d;
    assign idx = lcr_idx(s.chan);
    assign next_chan = lcr_next(s.chan);
    assign pi_go = s.fsm == LCR_CONV && done_rise && idx < `LCR_NUM_PWM;
    assign req_any = avs_req.read | avs_req.write;

    // ============================================================
    // Register read decode
    always_comb begin
        unique case (avs_req.address)
            `LCR_A_CTRL: begin
                rd_mux = {31'h0, s.run};
            end
            `LCR_A_REF: begin
                rd_mux = {16'h0, s.refv};
            end
            `LCR_A_KP: begin
                rd_mux = {16'h0, s.kp};
            end
            `LCR_A_KI: begin
                rd_mux = {16'h0, s.ki};
            end
            `LCR_A_UPPER: begin
                rd_mux = {16'h0, s.upper};
            end
            `LCR_A_LOWER: begin
                rd_mux = {16'h0, s.lower};
            end
            `LCR_A_STATUS: begin
                rd_mux = {19'h0, s.fsm != LCR_IDLE, s.chan, lower_saturation_flag, upper_saturation_flag};
            end
            `LCR_A_SAMPLE: begin
                rd_mux = {s.conv_cnt, s.sample};
            end
            default: begin
                if (avs_req.address[5:4] == `LCR_A_DUTY) begin
                    rd_mux = {16'h0, s.duty[avs_req.address[3:2]]};
                end else begin
                    rd_mux = 32'h0;
                end
            end
        endcase
    end

    // ============================================================
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        // First stage feeds only the second; edge detect looks at the second
        next_s.done_sync = {s.done_sync[0], adc_done};
        next_s.done_d = s.done_sync[1];
        next_s.data_sync = {s.data_sync[0], adc_data};
        next_s.div = proc_en ? 4'h0 : s.div + 4'h1;

        // Avalon slave: one wait cycle, then the answer
        next_s.ack = req_any & !s.ack;
        if (avs_req.read && !s.ack) begin
            next_s.rdata = rd_mux;
        end
        if (avs_req.write && s.ack) begin
            unique case (avs_req.address)
                `LCR_A_CTRL: begin
                    next_s.run = avs_req.writedata[0];
                end
                `LCR_A_REF: begin
                    next_s.refv = avs_req.writedata[15:0];
                end
                `LCR_A_KP: begin
                    next_s.kp = avs_req.writedata[15:0];
                end
                `LCR_A_KI: begin
                    next_s.ki = avs_req.writedata[15:0];
                end
                `LCR_A_UPPER: begin
                    next_s.upper = avs_req.writedata[15:0];
                end
                `LCR_A_LOWER: begin
                    next_s.lower = avs_req.writedata[15:0];
                end
                default: begin
                end
            endcase
        end

        // Conversion sequencing; run gates only new starts
        unique case (s.fsm)
            LCR_IDLE: begin
                if (upd && s.run) begin
                    next_s.start = 1'b1;
                    next_s.seen = 1'b1;
                    next_s.fsm = LCR_CONV;
                end
            end
            LCR_CONV: begin
                if (done_rise) begin
                    next_s.sample = s.data_sync[1];
                    next_s.conv_cnt = s.conv_cnt + 16'h0001;
                    if (idx < `LCR_NUM_PWM) begin
                        next_s.fsm = LCR_CALC;
                    end else begin
                        // Fifth input has no string; its sample is only reported
                        next_s.chan = next_chan;
                        next_s.fsm = LCR_IDLE;
                    end
                end
            end
            LCR_CALC: begin
                if (pi_done) begin
                    next_s.duty[idx[1:0]] = pi_out[15] ? 16'h0000 : pi_out;
                    next_s.chan = next_chan;
                    next_s.fsm = LCR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Carrier and regulator
    lcr_carrier u_carrier (
        .clk(clk),
        .resetn(resetn),
        .en(proc_en),
        .cmp_in(s.duty),
        .pwm(pwm_out),
        .ovf(ovf),
        .upd(upd)
    );

    lcr_pi u_pi (
        .clk(clk),
        .resetn(resetn),
        .go(pi_go),
        .chan(idx[1:0]),
        .sample(s.data_sync[1]),
        .refv(s.refv),
        .kp(s.kp),
        .ki(s.ki),
        .upper(s.upper),
        .lower(s.lower),
        .out(pi_out),
        .done(pi_done),
        .hi(upper_saturation_flag),
        .lo(lower_saturation_flag)
    );

    // ============================================================
    // Outputs
    assign adc_start = s.start;
    assign adc_channel = s.chan;
    assign avs_rsp.readdata = s.rdata;
    // Waitrequest is combinational so the master sees it in the request cycle
    assign avs_rsp.waitrequest = req_any & !s.ack;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_sample;
        s.fsm == LCR_CONV && done_rise && idx < `LCR_NUM_PWM;
    endsequence

    sequence s_step;
        pi_go ##1 pi_done;
    endsequence

    a_trigger_start: assert property (
        s.fsm == LCR_IDLE && upd && s.run |=> adc_start && s.fsm == LCR_CONV
    ) else $error("update did not start a conversion");

    a_single_shot: assert property (
        adc_start |=> (!adc_start)[*8]
    ) else $error("conversion start repeated");

    a_channel_range: assert property (
        adc_start |-> adc_channel >= `LCR_FIRST_CH && adc_channel <= `LCR_LAST_CH
    ) else $error("sense channel out of range");

    a_first_channel: assert property (
        $rose(s.seen) |-> adc_channel == `LCR_FIRST_CH
    ) else $error("first conversion not on channel 8");

    a_error_then_duty: assert property (
        s_sample |-> s_step
    ) else $error("sample did not run the regulator");

    a_duty_apply: assert property (
        s_step |=> s.duty[$past(idx[1:0], 2)] == ($past(pi_out[15]) ? 16'h0000 : $past(pi_out))
    ) else $error("regulator output not applied");

    a_upper_limit: assert property (
        pi_done && upper_saturation_flag[idx[1:0]] && !lower_saturation_flag[idx[1:0]] |-> pi_out == s.upper
    ) else $error("upper saturation without upper limit");

    a_lower_limit: assert property (
        pi_done && lower_saturation_flag[idx[1:0]] && !upper_saturation_flag[idx[1:0]] |-> pi_out == s.lower
    ) else $error("lower saturation without lower limit");

    a_within_limits: assert property (
        pi_done && !upper_saturation_flag[idx[1:0]] && !lower_saturation_flag[idx[1:0]]
        |-> $signed(pi_out) < $signed(s.upper) && $signed(pi_out) >= $signed(s.lower)
    ) else $error("unsaturated output outside limits");

    a_update_crest: assert property (
        upd |-> ovf ##1 !upd
    ) else $error("update event off the crest");

    a_bus_answer: assert property (
        req_any && avs_rsp.waitrequest |=> !avs_rsp.waitrequest
    ) else $error("bus answer later than one cycle");

    a_ctrl_write: assert property (
        avs_req.write && !avs_rsp.waitrequest && avs_req.address == `LCR_A_CTRL
        |=> s.run == $past(avs_req.writedata[0])
    ) else $error("control write lost");

    // Registers take a write only at the edge after the wait state, where waitrequest is low
    a_ref_write: assert property (
        avs_req.write && !avs_rsp.waitrequest && avs_req.address == `LCR_A_REF
        |=> s.refv == $past(avs_req.writedata[15:0])
    ) else $error("reference write lost");

    a_gain_write: assert property (
        avs_req.write && !avs_rsp.waitrequest && avs_req.address == `LCR_A_KP
        |=> s.kp == $past(avs_req.writedata[15:0])
    ) else $error("gain write lost");

    a_limit_write: assert property (
        avs_req.write && !avs_rsp.waitrequest && avs_req.address == `LCR_A_UPPER
        |=> s.upper == $past(avs_req.writedata[15:0])
    ) else $error("limit write lost");

    a_read_answer: assert property (
        avs_req.read && avs_rsp.waitrequest |=> avs_rsp.readdata == $past(rd_mux)
    ) else $error("read data not from the addressed register");

    // A start without a fresh update would sample one string twice in a row
    a_start_cause: assert property (
        adc_start |-> $past(upd) && $past(s.run) && $past(s.fsm) == LCR_IDLE
    ) else $error("conversion started without update");

    a_channel_hold: assert property (
        s.fsm != LCR_IDLE && !done_rise && !pi_done |=> $stable(adc_channel)
    ) else $error("sense channel moved during conversion");

    a_channel_order: assert property (
        $changed(adc_channel) |-> adc_channel == $past(next_chan) && s.fsm == LCR_IDLE
    ) else $error("sense channel out of rotation");

    a_sample_latch: assert property (
        s.fsm == LCR_CONV && done_rise
        |=> s.sample == $past(s.data_sync[1]) && s.conv_cnt == $past(s.conv_cnt) + 16'h0001
    ) else $error("conversion result not latched");

    a_fifth_skip: assert property (
        s.fsm == LCR_CONV && done_rise && adc_channel == `LCR_LAST_CH
        |-> !pi_go ##1 (s.fsm == LCR_IDLE && !pi_done)
    ) else $error("fifth input ran the regulator");

endmodule : lcr_top

// [lcr_map.svh]
// Register offsets, reset values and timing counts of the LED current regulator
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH
`define LCR_OSC_KHZ 24000
`define LCR_CLK_KHZ 100000
`define LCR_PROC_DIV 4'h1
`define LCR_PWM_KHZ 100
`define LCR_RELOAD 16'(`LCR_CLK_KHZ / (2 * `LCR_PWM_KHZ))
`define LCR_UPD_PERIODS 3'h5
`define LCR_FIRST_CH 4'h8
`define LCR_LAST_CH 4'hc
`define LCR_NUM_PWM 3'h4
`define LCR_P_SHIFT 12
`define LCR_I_SHIFT 16
`define LCR_SIGNED_HALFWORD_MAXIMUM 32'sh00007fff
`define LCR_A_CTRL 6'h00
`define LCR_A_REF 6'h04
`define LCR_A_KP 6'h08
`define LCR_A_KI 6'h0c
`define LCR_A_UPPER 6'h10
`define LCR_A_LOWER 6'h14
`define LCR_A_STATUS 6'h18
`define LCR_A_SAMPLE 6'h1c
`define LCR_A_DUTY 2'h2
`define LCR_RST_KP 16'h0400
`define LCR_RST_KI 16'h0040
`define LCR_RST_UPPER 16'h01c2
`endif

// [lcr_pkg.sv]
// Types shared by the LED current regulator
package lcr_pkg;
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
    } lcr_avs_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } lcr_avs_rsp_t;
    typedef enum logic [1:0] {LCR_IDLE, LCR_CONV, LCR_CALC} lcr_fsm_t;
    typedef logic [3:0][15:0] lcr_duty_t;
    typedef struct packed {
        logic [15:0] cnt;
        logic down;
        logic [2:0] upd_cnt;
        lcr_duty_t cmp;
        logic [3:0] pwm;
        logic ovf, unf, upd;
    } lcr_car_t;
    typedef struct packed {
        lcr_duty_t acc;
        logic [3:0] hi, lo;
        logic [15:0] out;
        logic done;
    } lcr_pi_t;
    typedef struct packed {
        lcr_fsm_t fsm;
        logic run, start, seen, ack, done_d;
        logic [15:0] refv, kp, ki, upper, lower, sample, conv_cnt;
        lcr_duty_t duty;
        logic [3:0] chan, div;
        logic [1:0] done_sync;
        logic [1:0][15:0] data_sync;
        logic [31:0] rdata;
    } lcr_top_t;
endpackage : lcr_pkg

// [lcr_carrier.sv]
// Center-aligned PWM carrier with crest update event
`timescale 1ns/1ps
`include "lcr_map.svh"
module lcr_carrier #(
    parameter logic [15:0] RELOAD = `LCR_RELOAD,
    parameter logic [2:0] UPD_PERIODS = `LCR_UPD_PERIODS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire lcr_pkg::lcr_duty_t cmp_in,
    output logic [3:0] pwm,
    output logic ovf,
    output logic upd
);
    import lcr_pkg::*;
    lcr_car_t s;
    lcr_car_t next_s;
    always_comb begin
        next_s = s;
        next_s.ovf = 1'b0;
        next_s.unf = 1'b0;
        next_s.upd = 1'b0;
        if (en && !s.down && s.cnt == RELOAD - 16'h0001) begin
            next_s.cnt = RELOAD;
            next_s.down = 1'b1;
            next_s.ovf = 1'b1;
            next_s.upd = s.upd_cnt == UPD_PERIODS - 3'h1;
            next_s.upd_cnt = next_s.upd ? 3'h0 : s.upd_cnt + 3'h1;
        end else if (en && !s.down) begin
            next_s.cnt = s.cnt + 16'h0001;
        end else if (en && s.cnt == 16'h0001) begin
            next_s.cnt = 16'h0000;
            next_s.down = 1'b0;
            next_s.unf = 1'b1;
            // Compares load at the trough so no period mixes two values
            next_s.cmp = cmp_in;
        end else if (en) begin
            next_s.cnt = s.cnt - 16'h0001;
        end
        for (int i = 0; i < 4; i++) begin
            next_s.pwm[i] = next_s.cnt >= next_s.cmp[i];
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{cmp: {4{RELOAD}}, default: '0};
        end else begin
            s <= next_s;
        end
    end
    assign pwm = s.pwm;
    assign ovf = s.ovf;
    assign upd = s.upd;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_crest_turn: assert property (s.ovf |-> s.down && s.cnt == RELOAD) else $error("overflow off crest");
    a_trough_turn: assert property (s.unf |-> !s.down && s.cnt == 16'h0000) else $error("underflow off trough");
endmodule : lcr_carrier

// [lcr_pi.sv]
// PI regulator with anti-windup, accumulator clamp and output limits
`timescale 1ns/1ps
`include "lcr_map.svh"
module lcr_pi (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic [1:0] chan,
    input wire logic [15:0] sample,
    input wire logic [15:0] refv,
    input wire logic [15:0] kp,
    input wire logic [15:0] ki,
    input wire logic [15:0] upper,
    input wire logic [15:0] lower,
    output logic [15:0] out,
    output logic done,
    output logic [3:0] hi,
    output logic [3:0] lo
);
    import lcr_pkg::*;
    lcr_pi_t s;
    lcr_pi_t next_s;
    logic signed [15:0] err, prop, inc, acc, acc_n, raw;
    logic signed [31:0] p_wide, i_wide, sum;
    always_comb begin
        next_s = s;
        next_s.done = go;
        err = 16'(refv - sample);
        p_wide = $signed(kp) * err;
        i_wide = $signed(ki) * err;
        prop = p_wide[15:0];
        inc = i_wide[15:0];
        acc = $signed(s.acc[chan]);
        sum = 32'(acc) + 32'(inc);
        acc_n = acc;
        if (acc >= 0 && inc >= 0) begin
            if (!s.hi[chan]) begin
                acc_n = (sum > `LCR_SIGNED_HALFWORD_MAXIMUM) ? 16'(`LCR_SIGNED_HALFWORD_MAXIMUM) : sum[15:0];
            end
        end else if (acc <= 0 && inc <= 0) begin
            if (!s.lo[chan]) begin
                acc_n = (sum < -`LCR_SIGNED_HALFWORD_MAXIMUM - 32'sd1) ? 16'(-`LCR_SIGNED_HALFWORD_MAXIMUM) : sum[15:0];
            end
        end else begin
            acc_n = sum[15:0];
        end
        raw = 16'((32'(prop) >>> `LCR_P_SHIFT) + (32'(acc_n) >>> `LCR_I_SHIFT));
        if (go) begin
            next_s.acc[chan] = acc_n;
            if (raw >= $signed(upper)) begin
                next_s.hi[chan] = 1'b1;
                next_s.out = upper;
            end else if (raw < $signed(lower)) begin
                next_s.lo[chan] = 1'b1;
                next_s.out = lower;
            end else begin
                next_s.hi[chan] = 1'b0;
                next_s.lo[chan] = 1'b0;
                next_s.out = raw;
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign out = s.out;
    assign done = s.done;
    assign hi = s.hi;
    assign lo = s.lo;
endmodule : lcr_pi

// [lcr_adc_model.sv]
// Converter partner: one single-shot conversion per start pulse, fast or slow
`timescale 1ns/1ps
module lcr_adc_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic adc_start,
    input wire logic [15:0] smp,
    input wire logic slow,
    output logic adc_done,
    output logic [15:0] adc_data
);
    logic [7:0] cnt;
    // ============================================================
    // Conversion sequencing
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            adc_done <= 1'b0;
            adc_data <= 16'h5a5a;
        end else if (cnt == 8'h00) begin
            // Released bus moves every cycle so a stale result never looks valid
            adc_data <= ~adc_data;
            if (adc_start) begin
                cnt <= slow ? 8'h30 : 8'h08;
            end
        end else begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h07) begin
                adc_done <= 1'b1;
                adc_data <= smp;
            end else if (cnt == 8'h01) begin
                adc_done <= 1'b0;
            end
        end
    end
endmodule : lcr_adc_model

// [tb_led_current_pi_regulator.sv]
// Self-checking bench of the LED current regulator
`timescale 1ns/1ps
`include "lcr_map.svh"
module tb_led_current_pi_regulator;
    import lcr_pkg::*;
    localparam int UPD_CYC = 2 * int'(`LCR_RELOAD) * int'(`LCR_UPD_PERIODS);
    logic clk, resetn, adc_start, adc_done, slow;
    logic [3:0] adc_channel, pwm_out, hi_f, lo_f, hi_m, lo_m, ch;
    logic [15:0] adc_data, smp, refv, kp, ki, up_l, lo_l;
    logic signed [15:0] acc_m [4];
    logic [15:0] duty_m [4];
    lcr_avs_req_t req;
    lcr_avs_rsp_t rsp;
    logic [31:0] rd_q [$];
    logic [3:0] ch_q [$];
    int mismatches, n_tests, seed, last_st, cyc, n;

    lcr_top dut (.clk(clk), .resetn(resetn), .avs_req(req), .avs_rsp(rsp), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data), .pwm_out(pwm_out),
        .upper_saturation_flag(hi_f), .lower_saturation_flag(lo_f));
    lcr_adc_model adc (.clk(clk), .resetn(resetn), .adc_start(adc_start), .smp(smp), .slow(slow),
        .adc_done(adc_done), .adc_data(adc_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(18 * UPD_CYC * 10);
        mismatches++;
        tally_and_finish();
    end

    // ============================================================
    // Bus master: request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        // Waitrequest is looked at on the rising edge itself, where the slave takes the transfer
        do begin
            @(posedge clk);
            k++;
        end while (rsp.waitrequest !== 1'b0 && k < 20);
        if (k >= 20) begin
            mismatches++;
        end
        req <= '0;
    endtask : bus

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Monitor: oldest note is taken whenever a result appears
    always @(posedge clk) begin
        cyc++;
        if (req.read && rsp.waitrequest === 1'b0) begin
            if (rd_q.size() == 0) begin
                mismatches++;
            end else begin
                chk(rsp.readdata, rd_q.pop_front());
            end
        end
        if (adc_start === 1'b1) begin
            if (ch_q.size() == 0) begin
                mismatches++;
                $display("[FAIL] %0t: unexpected conversion start", $time);
            end else begin
                chk(32'(adc_channel), 32'(ch_q.pop_front()));
            end
            if (last_st > 0) chk(32'(cyc - last_st), 32'(UPD_CYC));
            last_st = cyc;
        end
    end

    // ============================================================
    // Reference regulator, worked out independently
    function automatic void pi_step(input int s, input logic [15:0] x);
        logic signed [15:0] err, p, inc, o, a;
        int sum;
        a = acc_m[s];
        err = refv - x;
        p = $signed(kp) * err;
        inc = $signed(ki) * err;
        sum = a + inc;
        if (a >= 0 && inc >= 0) begin
            if (!hi_m[s]) a = sum > 32767 ? 16'sh7fff : 16'(sum);
        end else if (a <= 0 && inc <= 0) begin
            if (!lo_m[s]) a = sum < -32768 ? -16'sh7fff : 16'(sum);
        end else begin
            a = 16'(sum);
        end
        o = (p >>> 12) + (a >>> 16);
        if (o >= $signed(up_l)) begin
            hi_m[s] = 1'b1;
            o = up_l;
        end else if (o < $signed(lo_l)) begin
            lo_m[s] = 1'b1;
            o = lo_l;
        end else begin
            hi_m[s] = 1'b0;
            lo_m[s] = 1'b0;
        end
        acc_m[s] = a;
        duty_m[s] = o < 0 ? 16'h0000 : o;
    endfunction : pi_step

    // High time over one full carrier period, counter 0..reload-1 up and reload..1 down
    task automatic pwm_chk();
        int h [4];
        for (int i = 0; i < 4; i++) h[i] = 0;
        repeat (2 * `LCR_RELOAD) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) h[i] += (pwm_out[i] === 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            chk(32'(h[i]), duty_m[i] == 0 ? 32'(2 * `LCR_RELOAD) : 32'(2 * `LCR_RELOAD + 1 - 2 * duty_m[i]));
        end
    endtask : pwm_chk

    // ============================================================
    // Main sequence
    initial begin
        seed = 49;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        last_st = 0;
        resetn = 1'b0;
        req = '0;
        smp = 16'h0000;
        slow = 1'b0;
        refv = 16'h0800;
        kp = 16'h0600;
        ki = 16'($random(seed));
        up_l = 16'h0003;
        lo_l = 16'h0000;
        hi_m = 4'h0;
        lo_m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            acc_m[i] = 16'sh0000;
            duty_m[i] = `LCR_RELOAD;
        end
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        // Read-only and unmapped places ignore writes
        bus(1'b1, `LCR_A_STATUS, 32'hffffffff);
        bus(1'b1, 6'h30, 32'hffffffff);
        rd(`LCR_A_CTRL, 32'h0);
        rd(`LCR_A_REF, 32'h0);
        rd(`LCR_A_KP, 32'(`LCR_RST_KP));
        rd(`LCR_A_KI, 32'(`LCR_RST_KI));
        rd(`LCR_A_UPPER, 32'(`LCR_RST_UPPER));
        rd(`LCR_A_LOWER, 32'h0);
        rd(`LCR_A_STATUS, 32'h00000800);
        rd(`LCR_A_SAMPLE, 32'h0);
        rd(6'h30, 32'h0);
        rd(6'h3c, 32'h0);
        for (int i = 0; i < 4; i++) rd({`LCR_A_DUTY, 2'(i), 2'h0}, 32'(`LCR_RELOAD));
        // Stopped: no start across a whole update interval
        pwm_chk();
        repeat (UPD_CYC) @(posedge clk);
        bus(1'b1, `LCR_A_REF, {16'h0, refv});
        bus(1'b1, `LCR_A_KP, {16'h0, kp});
        bus(1'b1, `LCR_A_KI, {16'h0, ki});
        bus(1'b1, `LCR_A_UPPER, {16'h0, up_l});
        bus(1'b1, `LCR_A_LOWER, {16'h0, lo_l});
        rd(`LCR_A_KI, {16'h0, ki});
        rd(`LCR_A_UPPER, {16'h0, up_l});
        bus(1'b1, `LCR_A_CTRL, 32'h1);
        // Two full rotations, fast and slow converter answers alternating
        for (int k = 0; k < 10; k++) begin
            ch = 4'h8 + 4'(k % 5);
            ch_q.push_back(ch);
            smp <= 16'($random(seed)) & 16'h0fff;
            slow <= k[0];
            n = 0;
            while (adc_channel !== (ch == 4'hc ? 4'h8 : ch + 4'h1) && n < UPD_CYC + 100) begin
                @(negedge clk);
                n++;
            end
            if (n >= UPD_CYC + 100) begin
                mismatches++;
            end
            repeat (2) @(negedge clk);
            if (ch != 4'hc) begin
                pi_step(int'(ch[1:0]), smp);
                chk({28'h0, hi_f}, {28'h0, hi_m});
                chk({28'h0, lo_f}, {28'h0, lo_m});
                rd({`LCR_A_DUTY, ch[1:0], 2'h0}, {16'h0, duty_m[ch[1:0]]});
            end
            rd(`LCR_A_SAMPLE, {16'(k + 1), smp});
        end
        bus(1'b1, `LCR_A_CTRL, 32'h0);
        // New compares take effect at the next trough
        repeat (2 * `LCR_RELOAD + 100) @(posedge clk);
        pwm_chk();
        tally_and_finish();
    end
endmodule : tb_led_current_pi_regulator
